// ===== dv/tb_vcal_host.sv
// Self-checking bench for the host controller driving the calibrator model.
// Assumes the package is compiled first; both lines are resolved here with pull-ups.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_vcal_host;
    localparam int QC = 4;
    localparam logic [6:0] INIT_SET = 7'h35;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, scl_o, scl_oe_n, sda_o, sda_oe_n, dev_sda_low, scl_line, sda_line;
    logic supply_ok = 1'b0;
    logic [6:0] dev_dac, dev_store;
    int dev_bad, ref_dac, ref_store;
    int n_errors = 0;
    int checks_done = 0;

    // Wired-AND of both parties' pull-downs on the data line over the pull-ups; only the host pulls the clock line.
    assign scl_line = scl_oe_n ? 1'b1 : scl_o;
    assign sda_line = ((!sda_oe_n && !sda_o) || dev_sda_low) ? 1'b0 : 1'b1;

    vcal_host #(.QUARTER_CYC(QC)) vcal_host_i (.mclk(mclk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scl_i(scl_line), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

    vcal_dev_model #(.STORE_INIT(INIT_SET)) vcal_dev_model_i (.scl(scl_line), .sda(sda_line),
        .supply_ok(supply_ok), .sda_low(dev_sda_low), .dac(dev_dac), .store(dev_store),
        .bad_frames(dev_bad));

    // A 50 MHz system clock.
    initial begin
        forever #10 mclk = ~mclk;
    end

    // One Avalon access; the request stands until waitrequest is seen low at an edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        // Only the watchdog ends a wait that never sees waitrequest low.
        while (avs_waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask

    // Polls status until the engine is idle, under a bounded count.
    task automatic wait_done(output logic [31:0] st);
        int n;
        n = 0;
        st = 32'h0000_0001;
        while (st[0] !== 1'b0 && n < 2000) begin
            bus(1'b0, vcal_pkg::OFS_STATUS, 32'h0000_0000, st);
            n++;
        end
        if (n == 2000) n_errors++;
    endtask

    // A whole transaction: order it, wait for it, fetch the received byte.
    task automatic txn(input logic rw, input logic fin, input logic [6:0] s,
                       output logic [31:0] st, output logic [31:0] rx);
        logic [31:0] q;
        bus(1'b1, vcal_pkg::OFS_CMD, {22'h0, 1'b1, rw, fin, s}, q);
        wait_done(st);
        bus(1'b0, vcal_pkg::OFS_RXDATA, 32'h0000_0000, rx);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // The tests need some 5k cycles, so 20k cycles means a hang.
    initial begin
        #400_000;
        n_errors++;
        summarize();
    end

    initial begin
        logic [31:0] st, rx, q;
        logic [6:0] s;
        logic [6:0] tbl [4];
        int np;
        void'($urandom(32'h1112));
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        bus(1'b0, vcal_pkg::OFS_CMD, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0080)
        bus(1'b0, vcal_pkg::OFS_STATUS, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, q);
        bus(1'b0, 4'hC, 32'h0000_0000, q);
        `CHK(q, 32'h0000_0000)
        txn(1'b1, 1'b1, 7'h00, st, rx);
        `CHK(st[2:0], 3'b110)
        `CHK(rx[7:0], {INIT_SET, 1'b0})
        $display("test reset done");
        // Both ends of the code range, then random settings.
        tbl = '{7'h00, 7'h7F, 7'($urandom), 7'($urandom)};
        foreach (tbl[i]) begin
            txn(1'b0, 1'b1, tbl[i], st, rx);
            ref_dac = tbl[i];
            `CHK(st[3:0], 4'b0111 ^ 4'b1001)
            `CHK(dev_dac, 7'(ref_dac))
            txn(1'b1, 1'b1, 7'h00, st, rx);
            `CHK(rx[7:0], {7'(ref_dac), 1'b0})
        end
        $display("test load done");
        ref_store = INIT_SET;
        txn(1'b0, 1'b0, 7'($urandom), st, rx);
        `CHK(st[3:0], 4'b0110)
        `CHK(dev_store, 7'(ref_store))
        `CHK(dev_dac, 7'(ref_dac))
        $display("test low supply done");
        supply_ok <= 1'b1;
        s = ~7'(ref_dac);
        txn(1'b0, 1'b0, s, st, rx);
        ref_store = s;
        `CHK(st[3:0], 4'b1110)
        `CHK(dev_store, 7'(ref_store))
        txn(1'b1, 1'b1, 7'h00, st, rx);
        `CHK(st[2:0], 3'b010)
        np = 0;
        while (st[2] !== 1'b1 && np < 20) begin
            txn(1'b1, 1'b1, 7'h00, st, rx);
            np++;
        end
        `CHK(st[2:0], 3'b110)
        $display("test program and poll done");
        // A second go while busy must leave the first order untouched.
        s = 7'($urandom);
        ref_dac = s;
        bus(1'b1, vcal_pkg::OFS_CMD, {22'h0, 3'b101, s}, q);
        bus(1'b1, vcal_pkg::OFS_CMD, {22'h0, 3'b101, ~s}, q);
        bus(1'b0, vcal_pkg::OFS_STATUS, 32'h0000_0000, q);
        `CHK(q[0], 1'b1)
        wait_done(st);
        `CHK(dev_dac, 7'(ref_dac))
        `CHK(dev_bad, 0)
        `CHK({scl_o, sda_o}, 2'b00)
        $display("test busy refusal done");
        summarize();
    end
endmodule

`default_nettype wire

// ===== dv/vcal_dev_model.sv
// Behavioural model of the calibrator's two-wire slave, seen from the host.
// Assumes resolved open-drain lines with pull-ups; it only pulls the data line low.
`timescale 1ns/1ps
`default_nettype none

module vcal_dev_model #(
    parameter logic [6:0] CODE = 7'h4E,       // Device code that the model answers.
    parameter logic [6:0] STORE_INIT = 7'h35, // Stored setting at power-up.
    parameter int PROG_NS = 20000             // Length of one programming cycle.
) (
    input wire logic scl,       // Resolved clock line.
    input wire logic sda,       // Resolved data line.
    input wire logic supply_ok, // Programming supply above its threshold.
    output logic sda_low,       // High while pulling the data line low.
    output logic [6:0] dac,     // Setting that drives the sink current.
    output logic [6:0] store,   // Nonvolatile store contents.
    output int bad_frames       // Count of malformed frames.
);
    logic in_frame = 1'b0;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic prog_busy = 1'b0;
    int pulses = 0;
    int nbytes = 0;
    logic [7:0] sh = 8'h00;
    logic [7:0] rdbyte = 8'h00;

    // Power-up copies the store into the DAC before any access.
    initial begin
        store = STORE_INIT;
        dac = STORE_INIT;
        sda_low = 1'b0;
        bad_frames = 0;
    end

    // A falling data line under a high clock opens a frame.
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            if (in_frame) bad_frames++;
            in_frame = 1'b1;
            sel = 1'b1;
            pulses = 0;
            nbytes = 0;
        end
    end

    // A rising data line under a high clock closes it; the closing clock counts once.
    always @(posedge sda) begin
        if (scl === 1'b1 && in_frame) begin
            if (sel && (nbytes != 2 || pulses != 1)) bad_frames++;
            in_frame = 1'b0;
            sel = 1'b0;
            sda_low = 1'b0;
        end
    end

    // Data is sampled in the clock's high phase.
    always @(posedge scl) begin
        if (in_frame) begin
            pulses++;
            if (pulses <= 8) sh = {sh[6:0], sda};
        end
    end

    // The model changes its pull-down only after a falling clock, never in the high phase.
    always @(negedge scl) begin
        if (in_frame && sel) begin
            if (pulses == 8 && nbytes == 0) begin
                sel = (sh[7:1] == CODE) && !prog_busy;
                rd = sh[0];
                sda_low = sel;
            end else if (pulses == 8 && !rd) begin
                if (sh[0]) dac = sh[7:1];
                else if (supply_ok) begin
                    store = sh[7:1];
                    prog_busy = 1'b1;
                    fork
                        begin
                            #PROG_NS;
                            prog_busy = 1'b0;
                        end
                    join_none
                end
                sda_low = sh[0] || supply_ok;
            end else if (pulses == 9) begin
                nbytes++;
                pulses = 0;
                rdbyte = {dac, 1'b0};
                sda_low = rd && nbytes == 1 && !rdbyte[7];
            end else if (rd && nbytes == 1 && pulses >= 1) begin
                sda_low = (pulses < 8) && !rdbyte[7 - pulses];
            end
        end
    end
endmodule

`default_nettype wire

// ===== hdl/vcal_host.sv
// Host controller that drives the calibrator over its two-wire serial link.
// Assumes pull-ups at both lines and an Avalon-MM software master clocked by mclk.
// Contract
// R1: start only when both lines sit high
// R2: START is SDA falling while SCL high
// R3: STOP is SDA rising while SCL high
// R4: data changes only while SCL is low
// R5: one SCL clock per bit, both directions
// R6: exactly address byte then data byte
// R7: device answers only its fixed code
// R8: eighth address bit one reads, zero writes
// R9: address acked only if matched and idle
// R10: read returns setting then a zero bit
// R11: write setting with final bit one loads
// R12: final bit zero requests nonvolatile store
// R13: low programming supply refuses program command
// R14: higher code gives more sink current
// R15: every byte gets a ninth ack clock
// R16: acknowledger holds SDA low through ack high
// R17: master withholds ack after read byte
// R18: no acknowledge during programming cycle
// R19: poll with START plus address until acked
// R20: programming needs the programming supply high
// R21: device restores stored setting at power-up
// R22: device ignores traffic after foreign address
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module vcal_host #(
    parameter int QUARTER_CYC = vcal_pkg::QUARTER_CYC // Clocks per quarter bit.
) (
    input wire logic mclk,                // System clock.
    input wire logic rstn,                // Asynchronous reset, active low.
    input wire logic [3:0] avs_address,   // Byte address.
    input wire logic avs_read,            // Read request.
    input wire logic avs_write,           // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    output logic [31:0] avs_readdata,     // Read data.
    output logic avs_waitrequest,         // Stall until the answer.
    input wire logic scl_i,               // Serial clock line level.
    output logic scl_o,                   // Serial clock drive value.
    output logic scl_oe_n,                // Low while pulling the clock line.
    input wire logic sda_i,               // Serial data line level.
    output logic sda_o,                   // Serial data drive value.
    output logic sda_oe_n                 // Low while pulling the data line.
);

    // Line synchronisers; only the second stages are read by logic.
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // Quarter-bit divider; the link advances only on its one-cycle tick, except that a go leaves idle at once.
    logic [15:0] div_q, div_d;
    logic tick;
    always_comb begin
        tick = (div_q == 16'(QUARTER_CYC - 1));
        div_d = tick ? 16'h0000 : div_q + 16'h0001;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_d;
        end
    end

    // Link engine state.
    vcal_pkg::vcal_state_e st_q, st_d;
    vcal_pkg::vcal_pins_s pins_q, pins_d;
    vcal_pkg::vcal_cmd_s cmd_q, cmd_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] rx_q, rx_d;
    logic ack_q, ack_d;
    logic done_q, done_d;
    logic aack_q, aack_d;
    logic dack_q, dack_d;
    logic go;
    logic busy;
    logic drive_bit;

    // Software side: a go write is taken only while the link is idle.
    logic resp_q, resp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_take;

    assign busy = (st_q != vcal_pkg::VCAL_IDLE);
    assign wr_take = avs_write && resp_q && (avs_address == vcal_pkg::OFS_CMD);
    assign go = wr_take && avs_writedata[vcal_pkg::CMD_GO_BIT] && !busy;

    // Next values of the link engine, stepped once per quarter bit except the go out of idle.
    always_comb begin
        st_d = st_q;
        pins_d = pins_q;
        cmd_d = cmd_q;
        ph_d = ph_q;
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        ack_d = ack_q;
        done_d = done_q;
        aack_d = aack_q;
        dack_d = dack_q;
        // Read data bytes and every ack slot leave the data line to the device.
        drive_bit = (bit_q != vcal_pkg::ACK_SLOT)
            && (st_q == vcal_pkg::VCAL_ADDR || !cmd_q.rw) && !tx_q[7]; // R17
        if (wr_take && !busy) begin
            cmd_d.rw = avs_writedata[vcal_pkg::CMD_RW_BIT];
            cmd_d.final_bit = avs_writedata[vcal_pkg::CMD_FINAL_BIT];
            cmd_d.setting = avs_writedata[vcal_pkg::CMD_SET_LSB +: 7];
        end
        unique case (st_q)
            vcal_pkg::VCAL_IDLE: begin
                if (go) begin
                    st_d = vcal_pkg::VCAL_FREE;
                    done_d = 1'b0;
                    aack_d = 1'b0;
                    dack_d = 1'b0;
                    ph_d = 2'd0;
                    tx_d = {vcal_pkg::DEV_CODE, avs_writedata[vcal_pkg::CMD_RW_BIT]}; // R8
                end
            end
            vcal_pkg::VCAL_FREE: begin
                // Wait for a quiet bus before claiming it.
                if (tick && scl_s_q && sda_s_q) begin // R1
                    st_d = vcal_pkg::VCAL_START;
                end
            end
            vcal_pkg::VCAL_START: begin
                if (tick) begin
                    if (ph_q == 2'd0) begin
                        pins_d.sda_low = 1'b1; // R2
                        ph_d = 2'd1;
                    end else begin
                        pins_d.scl_low = 1'b1;
                        st_d = vcal_pkg::VCAL_ADDR;
                        bit_d = 4'd0;
                        ph_d = 2'd0;
                    end
                end
            end
            vcal_pkg::VCAL_ADDR, vcal_pkg::VCAL_DATA: begin
                if (tick) begin
                    unique case (ph_q)
                        2'd0: begin
                            pins_d.sda_low = drive_bit; // R4
                            ph_d = 2'd1;
                        end
                        2'd1: begin
                            pins_d.scl_low = 1'b0; // R5
                            // A held-low clock line stretches the bit.
                            if (scl_s_q) begin
                                ph_d = 2'd2;
                            end
                        end
                        2'd2: begin
                            if (bit_q == vcal_pkg::ACK_SLOT) begin
                                ack_d = !sda_s_q; // R15 R16
                            end else begin
                                rx_d = {rx_q[6:0], sda_s_q};
                            end
                            ph_d = 2'd3;
                        end
                        2'd3: begin
                            pins_d.scl_low = 1'b1;
                            ph_d = 2'd0;
                            if (bit_q == vcal_pkg::ACK_SLOT) begin
                                bit_d = 4'd0;
                                if (st_q == vcal_pkg::VCAL_ADDR && ack_q) begin
                                    st_d = vcal_pkg::VCAL_DATA; // R6
                                    aack_d = 1'b1;
                                    tx_d = {cmd_q.setting, cmd_q.final_bit}; // R11 R12
                                end else begin
                                    // A refused address ends the attempt; software polls.
                                    st_d = vcal_pkg::VCAL_STOP; // R19
                                    dack_d = (st_q == vcal_pkg::VCAL_DATA) && ack_q;
                                end
                            end else begin
                                bit_d = bit_q + 4'd1;
                                tx_d = {tx_q[6:0], 1'b0};
                            end
                        end
                        default: begin
                            ph_d = 2'd0;
                        end
                    endcase
                end
            end
            vcal_pkg::VCAL_STOP: begin
                if (tick) begin
                    unique case (ph_q)
                        2'd0: begin
                            pins_d.sda_low = 1'b1;
                            ph_d = 2'd1;
                        end
                        2'd1: begin
                            pins_d.scl_low = 1'b0;
                            if (scl_s_q) begin
                                ph_d = 2'd2;
                            end
                        end
                        default: begin
                            pins_d.sda_low = 1'b0; // R3
                            ph_d = 2'd0;
                            st_d = vcal_pkg::VCAL_IDLE;
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                st_d = vcal_pkg::VCAL_IDLE;
            end
        endcase
    end

    // Registers of the link engine.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= vcal_pkg::VCAL_IDLE;
            pins_q <= '0;
            cmd_q <= vcal_pkg::CMD_RESET[8:0];
            ph_q <= 2'd0;
            bit_q <= 4'd0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            ack_q <= 1'b0;
            done_q <= 1'b0;
            aack_q <= 1'b0;
            dack_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pins_q <= pins_d;
            cmd_q <= cmd_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            ack_q <= ack_d;
            done_q <= done_d;
            aack_q <= aack_d;
            dack_q <= dack_d;
        end
    end

    // Open-drain pins: the value is always low, the enable does the work.
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n = !pins_q.scl_low;
    assign sda_oe_n = !pins_q.sda_low;

    // Every access waits exactly one cycle, so read data comes from a register.
    always_comb begin
        resp_d = (avs_read || avs_write) && !resp_q;
        rdata_d = rdata_q;
        if (resp_d) begin
            unique case (avs_address)
                vcal_pkg::OFS_CMD: rdata_d = {22'h00_0000, busy, cmd_q};
                vcal_pkg::OFS_STATUS: rdata_d = {28'h000_0000, dack_q, aack_q, done_q, busy};
                vcal_pkg::OFS_RXDATA: rdata_d = {24'h00_0000, rx_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            resp_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            resp_q <= resp_d;
            rdata_q <= rdata_d;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !resp_q;
    assign avs_readdata = rdata_q;

    // Checks of the driven lines and of the sequence.
    a_start_bus_free: assert property (@(posedge mclk) disable iff (!rstn) // R1
        (st_q == vcal_pkg::VCAL_FREE && st_d == vcal_pkg::VCAL_START) |-> scl_s_q && sda_s_q)
        else $error("start claimed on a busy bus");
    a_sda_fall_edge: assert property (@(posedge mclk) disable iff (!rstn) // R2
        $rose(pins_q.sda_low) |-> pins_q.scl_low || st_q == vcal_pkg::VCAL_START)
        else $error("data pulled low while clock high outside start");
    a_sda_rise_edge: assert property (@(posedge mclk) disable iff (!rstn) // R3
        $fell(pins_q.sda_low) && !pins_q.scl_low |-> st_q == vcal_pkg::VCAL_IDLE)
        else $error("data released while clock high outside stop");
    a_data_stable_high: assert property (@(posedge mclk) disable iff (!rstn) // R4
        (st_q inside {vcal_pkg::VCAL_ADDR, vcal_pkg::VCAL_DATA} && !pins_q.scl_low
        && $past(!pins_q.scl_low)) |-> $stable(pins_q.sda_low))
        else $error("data changed while clock high");
    a_addr_code_sent: assert property (@(posedge mclk) disable iff (!rstn) // R8
        $rose(st_q == vcal_pkg::VCAL_FREE) |-> tx_q == {vcal_pkg::DEV_CODE, cmd_q.rw})
        else $error("address byte not the device code with direction");
    a_final_bit_sent: assert property (@(posedge mclk) disable iff (!rstn) // R11 R12
        $rose(st_q == vcal_pkg::VCAL_DATA) |-> tx_q == {cmd_q.setting, cmd_q.final_bit})
        else $error("data byte differs from the ordered setting");
    a_ack_slot_free: assert property (@(posedge mclk) disable iff (!rstn) // R15
        (bit_q == vcal_pkg::ACK_SLOT && ph_q == 2'd2) |-> !pins_q.sda_low)
        else $error("master drove the acknowledge slot");
    a_read_nack: assert property (@(posedge mclk) disable iff (!rstn) // R17
        (st_q == vcal_pkg::VCAL_DATA && cmd_q.rw && ph_q != 2'd0) |-> !pins_q.sda_low)
        else $error("master drove data during a read byte");
    a_nack_stops: assert property (@(posedge mclk) disable iff (!rstn) // R19
        (st_q == vcal_pkg::VCAL_ADDR && bit_q == vcal_pkg::ACK_SLOT && ph_q == 2'd3
        && tick && !ack_q) |=> st_q == vcal_pkg::VCAL_STOP && !aack_q)
        else $error("refused address did not end in stop");
    a_two_bytes_only: assert property (@(posedge mclk) disable iff (!rstn) // R6
        (st_q == vcal_pkg::VCAL_DATA) |=> st_q inside {vcal_pkg::VCAL_DATA, vcal_pkg::VCAL_STOP})
        else $error("more than two bytes in one transaction");
    a_data_then_stop: assert property (@(posedge mclk) disable iff (!rstn) // R6
        (st_q == vcal_pkg::VCAL_DATA && bit_q == vcal_pkg::ACK_SLOT && ph_q == 2'd3 && tick)
        |=> st_q == vcal_pkg::VCAL_STOP)
        else $error("data byte not followed by stop");

endmodule

`default_nettype wire

// ===== hdl/vcal_pkg.sv
// Package for the host controller of the calibrator's two-wire programming link.
// Assumes a 50 MHz system clock and a software master reached over Avalon-MM.
`default_nettype none
package vcal_pkg;

    // System clock rate and link bit timing.
    localparam int CLK_MHZ = 50;
    localparam int T_QUARTER_NS = 2500; // Quarter of a 10 us bit period.
    localparam int QUARTER_CYC_RAW = (T_QUARTER_NS * CLK_MHZ) / 1000;
    localparam int QUARTER_CYC = (QUARTER_CYC_RAW < 1) ? 1 : QUARTER_CYC_RAW;

    // Fixed 7-bit device code of the calibrator.
    localparam logic [6:0] DEV_CODE = 7'h4E;

    // Register byte offsets.
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RXDATA = 4'h8;

    // Command register fields.
    localparam int CMD_SET_LSB = 0;
    localparam int CMD_FINAL_BIT = 7;
    localparam int CMD_RW_BIT = 8;
    localparam int CMD_GO_BIT = 9;
    localparam logic [9:0] CMD_RESET = 10'h080;

    // Status register fields.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_AACK_BIT = 2;
    localparam int ST_DACK_BIT = 3;

    // Bit index of the acknowledge slot within a nine-clock byte.
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // Link controller states.
    typedef enum logic [2:0] {
        VCAL_IDLE,
        VCAL_FREE,
        VCAL_START,
        VCAL_ADDR,
        VCAL_DATA,
        VCAL_STOP
    } vcal_state_e;

    // One transaction as software orders it.
    typedef struct packed {
        logic rw;            // One for read, zero for write.
        logic final_bit;     // One loads the setting, zero programs the store.
        logic [6:0] setting; // DAC setting to send.
    } vcal_cmd_s;

    // Open-drain pull-downs of the two link lines.
    typedef struct packed {
        logic scl_low;
        logic sda_low;
    } vcal_pins_s;

endpackage

`default_nettype wire
